// ### hw/spectro_acq_ctrl.sv
// Acquisition timing, spectral stack and serial command interpreter
// Summary of operation
// - Single strobe is one 2 us high pulse at each integration start while the lamp line is high.
// - Continuous strobe is a 976 Hz square wave, equal high and low.
// - Both strobes are low while the lamp line is low, single strobe from the cycle after it falls.
// - Three trigger modes, chosen by the trigger-mode command.
// - Normal mode scans continuously at the host integration time.
// - Level mode captures at next period start after trigger went high.
// - Edge mode: rising trigger resets array, integrates fixed 50 ms.
// - Memory holds at most 16 spectra of 2048 points.
// - Spectra form a stack; newest is returned first.
// - Summing applied at send time; raw spectra stored.
// - Start with count 16 stores 16 scans, readable one by one.
// - Each command is one character, some followed by a 16-bit data value.
// - Values binary by default; 'a' selects ASCII, 'b' binary.
// - Reply 6 when accepted, 21 when rejected.
// - In ASCII format every command character is echoed.
// - Binary words are 16 bits, high byte first.
// - Version reply uses the currently selected value format.
// - Decoder handles the full documented command set.
// - Start command captures with the parameters already set.
// - Two legacy letters take a value and reply one rejection.
// - Lamp command drives line low for 0, high for 1; low at reset.
// - Integration time in ms, 5 to 65535, 100 after reset.
module spectro_acq_ctrl #(
  parameter int MS_CYCLES = acq_pkg::MS_CYC,
  parameter int HALF_CYC = acq_pkg::CONT_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic trig_in,
  input wire logic pix_valid,
  input wire logic [acq_pkg::DAT_W-1:0] pix_data,
  output logic ccd_start,
  output logic lamp_enable,
  output logic single_strobe,
  output logic cont_strobe
);
  import acq_pkg::*;
  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE, S_ECHO, S_GET_HI, S_GET_LO, S_GET_ASC, S_EXEC,
    S_SEND_ACK, S_SEND_WORD, S_RD_ADDR, S_RD_WAIT, S_RD_ACC
  } cmd_state_e;

  typedef struct packed {
    cmd_state_e st;
    logic [7:0] cmd;
    logic [15:0] val;
    logic ascii;
    logic lamp;
    trig_mode_e mode;
    logic [15:0] int_ms;
    logic [4:0] nsum;
    logic [3:0] box;
    logic comp;
    logic [2:0] baud;
    logic store_mode;
    logic partial;
    logic cksum;
    logic [7:0] txd;
    logic txv;
    logic ok;
    logic has_word;
    logic go_rd;
    logic [15:0] word;
    logic [1:0] bidx;
    logic [MW-1:0] ms_cnt;
    logic [15:0] ms_left;
    logic hw_run;
    logic trig_d;
    logic soft_seen;
    logic start;
    logic [4:0] pending;
    logic cap_on;
    logic [SLOT_W-1:0] cap_slot;
    logic [PIX_W-1:0] cap_pix;
    logic [4:0] depth;
    logic [PIX_W-1:0] rd_pix;
    logic [4:0] rd_s;
    logic [4:0] rd_n;
    logic [15:0] acc;
    logic [ADDR_W-1:0] raddr;
    logic [31:0] rdata;
    logic rd_ack;
  } ctrl_s;

  ctrl_s s, next_s;
  logic [DAT_W-1:0] mem_q;
  logic mem_we;
  logic boundary;
  logic cap_ok;
  logic [4:0] depth_inc;
  logic [4:0] depth_dec;
  logic [15:0] int_wr;

  // Commands that are followed by a data value
  function automatic logic has_data(input logic [7:0] c);
    case (c)
      C_SUM, C_BOX, C_LEG1, C_COMP, C_LEG2, C_INT, C_LAMP, C_BAUD, C_CLR,
      C_STORE, C_PART, C_TRIG, C_CKSUM, C_READ: has_data = 1'b1;
      default: has_data = 1'b0;
    endcase
  endfunction

  // One hex digit as an upper-case character
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n > 4'h9) begin
      hex_char = CH_HEX + {4'h0, n};
    end else begin
      hex_char = CH_0 + {4'h0, n};
    end
  endfunction

  // Memory ports driven straight from state so capture never waits
  assign mem_we = ce & s.cap_on & pix_valid;

  spectra_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr({s.cap_slot, s.cap_pix}),
    .wdata(pix_data),
    .raddr(s.raddr),
    .rdata(mem_q)
  );

  strobe_gen #(.HALF_CYC(HALF_CYC)) u_strobe (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .lamp(s.lamp),
    .period_start(s.start),
    .single_strobe(single_strobe),
    .cont_strobe(cont_strobe)
  );

  always_comb begin
    next_s = s;
    boundary = 1'b0;
    cap_ok = 1'b0;
    depth_inc = '0;
    depth_dec = '0;
    int_wr = s.int_ms;
    next_s.start = 1'b0;
    next_s.trig_d = trig_in;
    if (s.txv && tx_ready) begin
      next_s.txv = 1'b0;
    end

    // Millisecond tick and integration period timing
    if (s.ms_cnt == MS_LAST) begin
      next_s.ms_cnt = '0;
      if (s.mode == TRIG_HW) begin
        if (s.hw_run && s.ms_left == '0) begin
          boundary = 1'b1;
          cap_ok = 1'b1;
          next_s.hw_run = 1'b0;
        end else if (s.hw_run) begin
          next_s.ms_left = s.ms_left - 1'b1;
        end
      end else if (s.ms_left == '0) begin
        boundary = 1'b1;
        next_s.ms_left = s.int_ms - 1'b1;
        cap_ok = (s.mode == TRIG_NORMAL) | s.soft_seen;
        next_s.soft_seen = 1'b0;
      end else begin
        next_s.ms_left = s.ms_left - 1'b1;
      end
    end else begin
      next_s.ms_cnt = s.ms_cnt + 1'b1;
    end
    // Level trigger is remembered until the next period start
    if (s.mode == TRIG_SOFT && trig_in) begin
      next_s.soft_seen = 1'b1;
    end
    // Rising edge restarts a fixed internal integration
    if (s.mode == TRIG_HW && trig_in && !s.trig_d) begin
      boundary = 1'b1;
      cap_ok = 1'b0;
      next_s.hw_run = 1'b1;
      next_s.ms_left = HW_INT_MS - 1'b1;
      next_s.ms_cnt = '0;
    end
    next_s.start = boundary;

    // Capture the readout that follows a qualifying period start
    if (boundary && cap_ok && s.pending != '0 && !s.cap_on &&
        s.depth < SLOT_N) begin
      next_s.cap_on = 1'b1;
      next_s.cap_slot = s.depth[SLOT_W-1:0];
      next_s.cap_pix = '0;
      next_s.pending = s.pending - 1'b1;
    end
    if (s.cap_on && pix_valid) begin
      next_s.cap_pix = s.cap_pix + 1'b1;
      if (s.cap_pix == PIX_LAST) begin
        next_s.cap_on = 1'b0;
        depth_inc = 5'h01;
      end
    end

    // Avalon register slave; reads take one wait cycle
    next_s.rd_ack = avs_read & ~s.rd_ack;
    if (avs_read && !s.rd_ack) begin
      case (avs_address)
        REG_CTRL: next_s.rdata = {28'h0, s.ascii, s.mode, s.lamp};
        REG_STAT: next_s.rdata = {11'h0, s.pending, 7'h0, s.cap_on,
                                  3'h0, s.depth};
        REG_INT: next_s.rdata = {16'h0, s.int_ms};
        default: next_s.rdata = '0;
      endcase
    end
    if (avs_write) begin
      if (avs_address == REG_CTRL && avs_byteenable[0]) begin
        next_s.lamp = avs_writedata[CTRL_LAMP];
        if (avs_writedata[CTRL_MODE+1:CTRL_MODE] <= LIM_MODE[1:0]) begin
          next_s.mode = trig_mode_e'(avs_writedata[CTRL_MODE+1:CTRL_MODE]);
        end
        next_s.ascii = avs_writedata[CTRL_ASCII];
      end
      if (avs_address == REG_INT) begin
        int_wr = {avs_byteenable[1] ? avs_writedata[15:8] : s.int_ms[15:8],
                  avs_byteenable[0] ? avs_writedata[7:0] : s.int_ms[7:0]};
        if (int_wr >= INT_MIN) begin
          next_s.int_ms = int_wr;
        end
      end
    end

    // Serial command interpreter
    case (s.st)
      S_IDLE: begin
        if (rx_valid) begin
          next_s.cmd = rx_data;
          next_s.val = '0;
          next_s.has_word = 1'b0;
          next_s.go_rd = 1'b0;
          if (s.ascii) begin
            next_s.st = S_ECHO;
          end else if (has_data(rx_data)) begin
            next_s.st = S_GET_HI;
          end else begin
            next_s.st = S_EXEC;
          end
        end
      end
      S_ECHO: begin
        if (!s.txv) begin
          next_s.txd = s.cmd;
          next_s.txv = 1'b1;
          next_s.st = has_data(s.cmd) ? S_GET_ASC : S_EXEC;
        end
      end
      S_GET_HI: begin
        if (rx_valid) begin
          next_s.val[15:8] = rx_data;
          next_s.st = S_GET_LO;
        end
      end
      S_GET_LO: begin
        if (rx_valid) begin
          next_s.val[7:0] = rx_data;
          next_s.st = S_EXEC;
        end
      end
      S_GET_ASC: begin
        if (rx_valid) begin
          // Decimal digits accumulate; any other character ends the value
          if (rx_data >= CH_0 && rx_data <= CH_9) begin
            next_s.val = (s.val << 3) + (s.val << 1) +
                         {8'h0, rx_data - CH_0};
          end else begin
            next_s.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        next_s.ok = 1'b1;
        next_s.st = S_SEND_ACK;
        case (s.cmd)
          C_SUM: begin
            next_s.ok = s.val != '0 && s.val <= LIM_SUM;
            if (next_s.ok) next_s.nsum = s.val[4:0];
          end
          C_BOX: begin
            next_s.ok = s.val <= LIM_BOX;
            if (next_s.ok) next_s.box = s.val[3:0];
          end
          C_COMP: next_s.comp = s.val != '0;
          C_INT: begin
            next_s.ok = s.val >= INT_MIN;
            if (next_s.ok) next_s.int_ms = s.val;
          end
          C_LAMP: begin
            next_s.ok = s.val <= LIM_ONE;
            if (next_s.ok) next_s.lamp = s.val[0];
          end
          C_BAUD: begin
            next_s.ok = s.val <= LIM_BAUD;
            if (next_s.ok) next_s.baud = s.val[2:0];
          end
          C_CLR: next_s.depth = '0;
          C_STORE: begin
            next_s.ok = s.val <= LIM_ONE;
            if (next_s.ok) next_s.store_mode = s.val[0];
          end
          C_PART: next_s.partial = s.val[0];
          C_TRIG: begin
            next_s.ok = s.val <= LIM_MODE;
            if (next_s.ok) next_s.mode = trig_mode_e'(s.val[1:0]);
          end
          C_LEG1, C_LEG2: next_s.ok = 1'b0;
          C_CKSUM: next_s.cksum = s.val[0];
          C_START: next_s.pending = s.nsum;
          C_COUNT: begin
            next_s.has_word = 1'b1;
            next_s.word = {11'h0, s.depth};
          end
          C_READ: begin
            next_s.ok = s.depth != '0;
            next_s.go_rd = s.depth != '0;
            next_s.rd_n = (s.nsum < s.depth) ? s.nsum : s.depth;
            next_s.rd_pix = '0;
            next_s.rd_s = '0;
            next_s.acc = '0;
          end
          C_ASC: next_s.ascii = 1'b1;
          C_BIN: next_s.ascii = 1'b0;
          C_VER: begin
            next_s.has_word = 1'b1;
            next_s.word = VERSION_DEF;
          end
          default: next_s.ok = 1'b0;
        endcase
      end
      S_SEND_ACK: begin
        if (!s.txv) begin
          next_s.txd = s.ok ? ACK : NAK;
          next_s.txv = 1'b1;
          next_s.bidx = '0;
          if (s.has_word) begin
            next_s.st = S_SEND_WORD;
          end else if (s.go_rd) begin
            next_s.st = S_RD_ADDR;
          end else begin
            next_s.st = S_IDLE;
          end
        end
      end
      S_SEND_WORD: begin
        if (!s.txv) begin
          next_s.txv = 1'b1;
          next_s.bidx = s.bidx + 1'b1;
          // ASCII sends four hex characters, binary two bytes
          if (s.ascii) begin
            next_s.txd = hex_char(s.word[15 - 4 * s.bidx -: 4]);
          end else begin
            next_s.txd = s.bidx[0] ? s.word[7:0] : s.word[15:8];
          end
          if ((s.ascii && s.bidx == 2'h3) || (!s.ascii && s.bidx[0])) begin
            if (!s.go_rd) begin
              next_s.st = S_IDLE;
            end else if (s.rd_pix == PIX_LAST) begin
              depth_dec = s.rd_n;
              next_s.st = S_IDLE;
            end else begin
              next_s.rd_pix = s.rd_pix + 1'b1;
              next_s.st = S_RD_ADDR;
            end
          end
        end
      end
      S_RD_ADDR: begin
        // Newest slot first, then the ones beneath it
        next_s.raddr = {SLOT_W'(s.depth - 5'h01 - s.rd_s), s.rd_pix};
        next_s.st = S_RD_WAIT;
      end
      S_RD_WAIT: next_s.st = S_RD_ACC;
      S_RD_ACC: begin
        if (s.rd_s == s.rd_n - 1'b1) begin
          next_s.word = s.acc + {4'h0, mem_q};
          next_s.acc = '0;
          next_s.rd_s = '0;
          next_s.bidx = '0;
          next_s.st = S_SEND_WORD;
        end else begin
          next_s.acc = s.acc + {4'h0, mem_q};
          next_s.rd_s = s.rd_s + 1'b1;
          next_s.st = S_RD_ADDR;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    // Net stack change: clear wins, else finished capture minus pop
    if (!(s.st == S_EXEC && s.cmd == C_CLR)) begin
      next_s.depth = s.depth + depth_inc - depth_dec;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= S_IDLE;
      s.mode <= TRIG_NORMAL;
      s.int_ms <= INT_DEF;
      s.nsum <= SUM_DEF;
      s.baud <= BAUD_DEF;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs
  assign rx_ready = (s.st == S_IDLE) | (s.st == S_GET_HI) |
                    (s.st == S_GET_LO) | (s.st == S_GET_ASC);
  assign tx_data = s.txd;
  assign tx_valid = s.txv;
  assign ccd_start = s.start;
  assign lamp_enable = s.lamp;
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = avs_read & ~s.rd_ack;
endmodule // spectro_acq_ctrl

// ### hw/acq_pkg.sv
// Shared constants and types for the spectrometer acquisition controller
package acq_pkg;
  // Clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int STROBE_NS = 2000;
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CONT_HZ = 976;
  localparam int CONT_HALF_CYC = CLK_HZ / (2 * CONT_HZ);
  localparam int MS_CYC = CLK_HZ / 1000;
  // Spectral memory geometry
  localparam int PIX_W = 11;
  localparam int SLOT_W = 4;
  localparam int DAT_W = 12;
  localparam int ADDR_W = PIX_W + SLOT_W;
  localparam logic [PIX_W-1:0] PIX_LAST = 11'h7FF;
  localparam logic [4:0] SLOT_N = 5'h10;
  // Parameter limits and power-up values
  localparam logic [15:0] INT_MIN = 16'h0005;
  localparam logic [15:0] INT_DEF = 16'h0064;
  localparam logic [15:0] HW_INT_MS = 16'h0032;
  localparam logic [15:0] LIM_SUM = 16'h0010;
  localparam logic [15:0] LIM_BOX = 16'h000F;
  localparam logic [15:0] LIM_ONE = 16'h0001;
  localparam logic [15:0] LIM_BAUD = 16'h0006;
  localparam logic [15:0] LIM_MODE = 16'h0002;
  localparam logic [4:0] SUM_DEF = 5'h01;
  localparam logic [2:0] BAUD_DEF = 3'h2;
  localparam logic [15:0] VERSION_DEF = 16'h0100; // Arbitrary value
  // Reply bytes and characters
  localparam logic [7:0] ACK = 8'h06;
  localparam logic [7:0] NAK = 8'h15;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_HEX = 8'h37;
  // Command letters
  localparam logic [7:0] C_SUM = 8'h41, C_BOX = 8'h42, C_LEG1 = 8'h46;
  localparam logic [7:0] C_COMP = 8'h47, C_LEG2 = 8'h48, C_INT = 8'h49;
  localparam logic [7:0] C_LAMP = 8'h4A, C_BAUD = 8'h4B, C_CLR = 8'h4C;
  localparam logic [7:0] C_STORE = 8'h4D, C_PART = 8'h50, C_START = 8'h53;
  localparam logic [7:0] C_TRIG = 8'h54, C_COUNT = 8'h57, C_READ = 8'h5A;
  localparam logic [7:0] C_ASC = 8'h61, C_BIN = 8'h62, C_CKSUM = 8'h6B;
  localparam logic [7:0] C_VER = 8'h76;
  // Register map (byte addresses) and field positions
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_INT = 4'h8;
  localparam int CTRL_LAMP = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ASCII = 3;
  localparam int STAT_CAP = 8;
  localparam int STAT_PEND = 16;
  typedef enum logic [1:0] {TRIG_NORMAL, TRIG_SOFT, TRIG_HW} trig_mode_e;
endpackage

// ### hw/spectra_mem.sv
// Spectral memory: 16 slots of 2048 samples, registered read port
module spectra_mem (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [acq_pkg::ADDR_W-1:0] waddr,
  input wire logic [acq_pkg::DAT_W-1:0] wdata,
  input wire logic [acq_pkg::ADDR_W-1:0] raddr,
  output logic [acq_pkg::DAT_W-1:0] rdata
);
  import acq_pkg::*;
  logic [DAT_W-1:0] mem [(1 << ADDR_W)];

  // No reset: contents are only valid where the stack depth says so
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // spectra_mem

// ### hw/strobe_gen.sv
// Single and continuous strobe generator gated by the lamp line
module strobe_gen #(
  parameter int HALF_CYC = acq_pkg::CONT_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic lamp,
  input wire logic period_start,
  output logic single_strobe,
  output logic cont_strobe
);
  import acq_pkg::*;
  localparam int SW = $clog2(STROBE_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam logic [SW-1:0] S_LAST = SW'(STROBE_CYC - 1);
  localparam logic [HW-1:0] H_LAST = HW'(HALF_CYC - 1);
  typedef struct packed {
    logic [SW-1:0] scnt;
    logic single;
    logic [HW-1:0] hcnt;
    logic cont;
  } strobe_s;
  strobe_s s, next_s;

  // Pulse at each period start while the lamp is on; square wave always runs, output gated
  always_comb begin
    next_s = s;
    if (s.single) begin
      next_s.scnt = s.scnt + 1'b1;
      if (s.scnt == S_LAST) begin
        next_s.single = 1'b0;
      end
    end
    if (period_start && lamp) begin
      next_s.single = 1'b1;
      next_s.scnt = '0;
    end
    if (!lamp) begin
      next_s.single = 1'b0;
    end
    if (s.hcnt == H_LAST) begin
      next_s.hcnt = '0;
      next_s.cont = ~s.cont;
    end else begin
      next_s.hcnt = s.hcnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign single_strobe = s.single;
  assign cont_strobe = s.cont & lamp;
endmodule // strobe_gen

// ### verification/spectro_acq_ctrl_assertions.sv
// Port checker for the acquisition controller, bound to its top
module acq_chk
  import acq_pkg::*;
#(
  parameter int MS_CYCLES = 20,
  parameter int HALF_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic ccd_start,
  input wire logic lamp_enable,
  input wire logic single_strobe,
  input wire logic cont_strobe
);
  int run_s;
  int run_c;
  logic c_q;
  logic [1:0] seen;
  logic chg;
  assign chg = cont_strobe != c_q;
  // Run lengths; two changes are needed before a wave half is whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_s <= 0;
      run_c <= 0;
      c_q <= 1'b0;
      seen <= 2'h0;
    end else begin
      run_s <= single_strobe ? run_s + 1 : 0;
      run_c <= chg ? 1 : run_c + 1;
      c_q <= cont_strobe;
      seen <= !lamp_enable ? 2'h0 : (chg ? {seen[0], 1'b1} : seen);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_single; !single_strobe && run_s != 0 && lamp_enable
    |-> run_s == STROBE_CYC; endproperty
  a_single: assert property (p_single)
    else $error("single strobe width wrong");
  property p_cont; lamp_enable && chg && seen[1] |-> run_c == HALF_CYC;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous strobe half period wrong");
  property p_gate; !lamp_enable |-> !cont_strobe; endproperty
  a_gate: assert property (p_gate)
    else $error("continuous strobe without lamp");
  property p_gate1; !lamp_enable && !$past(lamp_enable) |-> !single_strobe;
  endproperty
  a_gate1: assert property (p_gate1)
    else $error("single strobe without lamp");
  property p_lamp0; $fell(rst) |-> !lamp_enable; endproperty
  a_lamp0: assert property (p_lamp0)
    else $error("lamp line high after reset");
  property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("read wait state count wrong");
  property p_nowait; !avs_read |-> !avs_waitrequest; endproperty
  a_nowait: assert property (p_nowait)
    else $error("wait without read");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply byte dropped or changed");
  property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_gap: assert property (p_gap)
    else $error("no idle cycle between replies");
  property p_busy; $rose(tx_valid) |-> !$past(rx_ready); endproperty
  a_busy: assert property (p_busy)
    else $error("reply began while input was open");
  property p_pulse; ccd_start |=> !ccd_start; endproperty
  a_pulse: assert property (p_pulse)
    else $error("start pulse longer than one cycle");
  c_tx: cover property (tx_valid && !tx_ready);
  c_strobe: cover property (ccd_start && lamp_enable);
  c_rd: cover property ($rose(avs_read));
endmodule // acq_chk

bind spectro_acq_ctrl acq_chk #(.MS_CYCLES(MS_CYCLES), .HALF_CYC(HALF_CYC))
  acq_chk_inst (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .ccd_start(ccd_start), .lamp_enable(lamp_enable),
  .single_strobe(single_strobe), .cont_strobe(cont_strobe));

// ### verification/host_model.sv
// Serial host that sends command bytes and takes replies
module host_model (
  input wire logic clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Random stalls make the device hold its reply bytes
  always @(posedge clk) tx_ready <= ($urandom_range(0, 2) != 0);
  // One byte, held until taken; the data line then shows junk
  task send(input logic [7:0] b);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    while (!rx_ready) @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    @(posedge clk);
  endtask
  task get(output logic [7:0] b);
    @(posedge clk);
    while (!(tx_valid && tx_ready)) @(posedge clk);
    b = tx_data;
  endtask
endmodule // host_model

// ### verification/spectro_acq_timing_cmd_ctrl_tb_top.sv
// Self-checking bench for the acquisition controller
module spectro_acq_timing_cmd_ctrl_tb_top;
  import acq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 20;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic avs_waitrequest, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, b;
  logic trig_in = 1'b0, pv_r = 1'b0, pix_valid, ccd_start;
  logic [11:0] pix_data = 12'h000;
  logic lamp_enable, single_strobe, cont_strobe;
  logic [15:0] w;
  logic [11:0] stk [16][$];
  int n_fail = 0, cmp_count = 0, cyc = 0, pend = 0, depth = 0, cap = 0;
  int t;
  always #20 clk = ~clk;
  spectro_acq_ctrl #(.MS_CYCLES(MSC), .HALF_CYC(8)) spectro_acq_ctrl_inst (
    .clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .trig_in(trig_in), .pix_valid(pix_valid), .pix_data(pix_data),
    .ccd_start(ccd_start), .lamp_enable(lamp_enable),
    .single_strobe(single_strobe), .cont_strobe(cont_strobe));
  host_model host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  // No sample in a start cycle, so its counting is never in doubt
  assign pix_valid = pv_r & ~ccd_start;
  always @(posedge clk) begin
    pv_r <= ($urandom_range(0, 3) != 0);
    pix_data <= 12'($urandom);
  end
  // Stack model and hang limit
  always @(posedge clk) begin
    cyc++;
    if (cap > 0 && pix_valid) begin
      stk[depth].push_back(pix_data);
      cap--;
      if (cap == 0) depth++;
    end else if (ccd_start && pend > 0 && depth < 16 && cap == 0) begin
      pend--;
      cap = 2048;
      stk[depth].delete();
    end
    if (cyc > 60000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] q);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task cmd(input logic [7:0] c, input int v, input logic [7:0] r);
    host.send(c);
    if (v >= 0) begin
      host.send(8'(v >> 8));
      host.send(8'(v));
    end
    if (c == C_START) pend = 2;
    host.get(b);
    chk(b, r);
  endtask
  task getw;
    host.get(w[15:8]);
    host.get(w[7:0]);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h1F8BB83C));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_CTRL, d);
    chk(d[3:0], 4'h0);
    rd(REG_INT, d);
    chk(d[15:0], INT_DEF);
    rd(REG_STAT, d);
    chk(d[4:0], 5'h00);
    rd(4'hC, d);
    chk(d, 32'h0);
    chk(lamp_enable, 1'b0);
    cmd(C_INT, 4, NAK);
    cmd(C_INT, 300, ACK);
    wr(REG_INT, 32'h3);
    wr(REG_INT, 32'hC8);
    rd(REG_INT, d);
    chk(d[15:0], 16'h00C8);
    cmd(C_LAMP, 2, NAK);
    cmd(C_LAMP, 1, ACK);
    chk(lamp_enable, 1'b1);
    cmd(C_LEG1, 7, NAK);
    cmd(C_LEG2, 7, NAK);
    for (int m = 0; m < 4; m++) begin
      cmd(C_TRIG, m, m < 3 ? ACK : NAK);
      rd(REG_CTRL, d);
      chk(d[2:1], m < 3 ? m : 2);
    end
    // Edge mode: a rising trigger opens one fixed-length integration
    trig_in <= 1'b1;
    t = 0;
    while (!ccd_start && t < 200) begin
      @(posedge clk);
      t++;
    end
    t = 0;
    @(posedge clk);
    while (!ccd_start && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk(t >= 50 * MSC - 2 && t <= 50 * MSC, 1'b1);
    // Let the strobe pulse end before normal mode opens a new period
    repeat (60) @(posedge clk);
    trig_in <= 1'b0;
    cmd(C_TRIG, 0, ACK);
    cmd(C_SUM, 2, ACK);
    cmd(C_START, -1, ACK);
    t = 0;
    while (depth < 2 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    cmd(C_COUNT, -1, ACK);
    getw;
    chk(w, 16'h2);
    cmd(C_SUM, 1, ACK);
    cmd(C_READ, 1, ACK);
    for (int i = 0; i < 2048; i++) begin
      getw;
      chk(w, {4'h0, stk[1][i]});
    end
    cmd(C_COUNT, -1, ACK);
    getw;
    chk(w, 16'h1);
    cmd(C_CLR, 0, ACK);
    cmd(C_READ, 1, NAK);
    cmd(C_VER, -1, ACK);
    getw;
    chk(w, VERSION_DEF);
    cmd(C_ASC, -1, ACK);
    host.send(C_VER);
    for (int k = 0; k < 6; k++) begin
      host.get(b);
      if (k < 2) chk(b, k == 0 ? C_VER : ACK);
      else chk(b, VERSION_DEF[23-4*k -: 4] < 10 ?
        CH_0 + VERSION_DEF[23-4*k -: 4] :
        CH_HEX + VERSION_DEF[23-4*k -: 4]);
    end
    host.send(C_BIN);
    host.get(b);
    chk(b, C_BIN);
    host.get(b);
    chk(b, ACK);
    cmd(C_VER, -1, ACK);
    getw;
    chk(w, VERSION_DEF);
    cmd(C_LAMP, 0, ACK);
    chk(lamp_enable, 1'b0);
    repeat (60) @(posedge clk);
    close_out;
  end
endmodule // spectro_acq_timing_cmd_ctrl_tb_top
